// file: logic/ssb_pkg.sv
// Shared constants and types for the burst SRAM access control
package ssb_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 18;
   localparam int LANE_W = 9;
   localparam int DEPTH = 262144;
   localparam int BURST_W = 2;
   // Sleep entry and exit, in clock cycles
   localparam int SLEEP_CYC = 2;
   localparam logic [1:0] SLEEP_CNT_MAX = 2'(SLEEP_CYC - 1);
   localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
   // Clock-to-data-valid figure; output is registered from the array at the coming-edge address
   localparam real CLOCK_TO_DATA_VALID_TIME_NS = 6.5;
   typedef enum logic [1:0] {
      SSB_IDLE = 2'b00,
      SSB_READ = 2'b01,
      SSB_WRITE = 2'b10
   } ssb_cycle_t;
   typedef enum logic [1:0] {
      SSB_AWAKE = 2'b00,
      SSB_ENTER = 2'b01,
      SSB_ASLEEP = 2'b10,
      SSB_EXIT = 2'b11
   } ssb_sleep_t;
endpackage

// file: logic/ssb_burst_ctr.sv
// Two-bit wraparound burst counter with linear or interleaved order
`timescale 1ns/1ps
module ssb_burst_ctr
   import ssb_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic load_i,
   input wire logic [ssb_pkg::BURST_W-1:0] start_i,
   input wire logic step_i,
   input wire logic linear_i,
   output logic [ssb_pkg::BURST_W-1:0] addr_o
);
   logic [BURST_W-1:0] start_q, start_d;
   logic [BURST_W-1:0] beat_q, beat_d;

   // Next start and beat count
   always_comb begin
      start_d = start_q;
      beat_d = beat_q;
      if (load_i) begin
         start_d = start_i;
         beat_d = BURST_ZERO;
      end else if (step_i) begin
         beat_d = beat_q + BURST_STEP;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         start_q <= BURST_ZERO;
         beat_q <= BURST_ZERO;
      end else begin
         start_q <= start_d;
         beat_q <= beat_d;
      end
   end

   // Beat address for the coming edge, so reads stay flow-through
   // linear add or interleaved XOR order
   always_comb begin
      if (linear_i) begin
         addr_o = start_d + beat_d;
      end else begin
         addr_o = start_d ^ beat_d;
      end
   end
endmodule

// file: logic/ssb_access_ctrl.sv
// Access control and storage of the flow-through burst SRAM
`timescale 1ns/1ps
// Summary of operation
// - All chip selects active plus a strobe starts an access; first select high blocks processor strobe.
// - Access start captures address and loads low bits into burst counter.
// - Read data appears flow-through in the same cycle when output enable low.
// - Processor-strobe start ignores all write inputs; first cycle is a read.
// - Write indicated the edge after a processor start stores the data bus.
// - Lane inputs A and B each gate their own byte lane.
// - Detected write cycles float the data pins whatever output enable is.
// - Controller strobe alone with write indicated starts a write that same cycle.
// - Both strobes low means only the processor strobe counts.
// - Two-bit wraparound counter, loaded from low address bits, makes four beats.
// - Order select low gives linear order, high gives interleaved.
// - Interleaved order XORs start bits with beat count.
// - Linear order adds beat count to start modulo four.
// - Both strobes high, advance low: step counter and access next address.
// - Both strobes high, advance high: hold counter and repeat access.
// - Continuing and suspended writes take data regardless of output enable.
// - Sleep input enters retention sleep in two cycles; data pins float.
// - Accesses in progress at sleep entry are dropped as invalid.
// - Write indicated by global store low, or lane enable low with a lane.
// - Global store low writes all lanes, overriding lane inputs.
module ssb_access_ctrl
   import ssb_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [ssb_pkg::ADDR_W-1:0] addr_i,
   input wire logic processor_addr_strobe_n_i,
   input wire logic controller_addr_strobe_n_i,
   input wire logic burst_advance_n_i,
   input wire logic chip_sel_first_n_i,
   input wire logic chip_sel_second_i,
   input wire logic chip_sel_third_n_i,
   input wire logic global_store_n_i,
   input wire logic lane_store_enable_n_i,
   input wire logic lane_a_store_n_i,
   input wire logic lane_b_store_n_i,
   input wire logic output_enable_n_i,
   input wire logic burst_order_i,
   input wire logic sleep_request_i,
   input wire logic [ssb_pkg::DATA_W-1:0] data_i,
   output logic [ssb_pkg::DATA_W-1:0] data_o,
   output logic data_oe_n_o,
   output logic asleep_o
);
   import ssb_pkg::*;

   logic [LANE_W-1:0] mem_a [DEPTH];
   logic [LANE_W-1:0] mem_b [DEPTH];

   ssb_cycle_t cyc_q, cyc_d;
   ssb_sleep_t slp_q, slp_d;
   logic [1:0] slp_cnt_q, slp_cnt_d;
   logic [ADDR_W-1:0] base_q, base_d;
   logic proc_start_q, proc_start_d;
   logic ctr_load, ctr_step;
   logic [BURST_W-1:0] burst_low;
   logic [ADDR_W-1:0] cur_addr;
   logic selected, proc_go, ctrl_go, cont, wr_ind, awake;
   logic lane_a_we, lane_b_we;

   // Write indicator decode from the store inputs
   function automatic logic write_ind(input logic g_n, input logic e_n,
                                      input logic a_n, input logic b_n);
      return !g_n || (!e_n && (!a_n || !b_n));
   endfunction

   // Lane write decode; global store covers every lane
   function automatic logic lane_we(input logic g_n, input logic e_n, input logic l_n);
      return !g_n || (!e_n && !l_n);
   endfunction

   // Start and continuation decode
   always_comb begin
      awake = (slp_q == SSB_AWAKE);
      selected = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i;
      wr_ind = write_ind(global_store_n_i, lane_store_enable_n_i,
                         lane_a_store_n_i, lane_b_store_n_i);
      proc_go = awake && selected && !processor_addr_strobe_n_i;
      ctrl_go = awake && selected && processor_addr_strobe_n_i
                && !controller_addr_strobe_n_i;
      cont = awake && controller_addr_strobe_n_i
             && (processor_addr_strobe_n_i || chip_sel_first_n_i)
             && (cyc_q != SSB_IDLE);
   end

   // Access state next values
   always_comb begin
      cyc_d = cyc_q;
      base_d = base_q;
      proc_start_d = 1'b0;
      ctr_load = 1'b0;
      ctr_step = 1'b0;
      if (!awake) begin
         cyc_d = SSB_IDLE;
      end else if (proc_go) begin
         base_d = addr_i;
         ctr_load = 1'b1;
         cyc_d = SSB_READ;
         proc_start_d = 1'b1;
      end else if (ctrl_go) begin
         base_d = addr_i;
         ctr_load = 1'b1;
         cyc_d = wr_ind ? SSB_WRITE : SSB_READ;
      end else if (cont) begin
         cyc_d = wr_ind ? SSB_WRITE : SSB_READ;
         ctr_step = !burst_advance_n_i;
      end else if (!controller_addr_strobe_n_i || !processor_addr_strobe_n_i) begin
         cyc_d = SSB_IDLE;
      end
   end

   // Access state registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cyc_q <= SSB_IDLE;
         base_q <= '0;
         proc_start_q <= 1'b0;
      end else begin
         cyc_q <= cyc_d;
         base_q <= base_d;
         proc_start_q <= proc_start_d;
      end
   end

   ssb_burst_ctr u_ctr (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .load_i(ctr_load),
      .start_i(base_d[BURST_W-1:0]),
      .step_i(ctr_step),
      .linear_i(!burst_order_i),
      .addr_o(burst_low)
   );

   assign cur_addr = {base_d[ADDR_W-1:BURST_W], burst_low}; // Address used at the coming edge

   // Lane enables for the current write beat
   always_comb begin
      lane_a_we = 1'b0;
      lane_b_we = 1'b0;
      if (awake && cont && wr_ind) begin
         lane_a_we = lane_we(global_store_n_i, lane_store_enable_n_i, lane_a_store_n_i);
         lane_b_we = lane_we(global_store_n_i, lane_store_enable_n_i, lane_b_store_n_i);
      end
   end

   // Array write; controller-start writes store at the captured address
   always_ff @(posedge clk_i) begin
      if (lane_a_we) begin
         mem_a[cur_addr] <= data_i[LANE_W-1:0];
      end
      if (lane_b_we) begin
         mem_b[cur_addr] <= data_i[DATA_W-1:LANE_W];
      end
      if (ctrl_go && wr_ind) begin
         if (lane_we(global_store_n_i, lane_store_enable_n_i, lane_a_store_n_i)) begin
            mem_a[addr_i] <= data_i[LANE_W-1:0];
         end
         if (lane_we(global_store_n_i, lane_store_enable_n_i, lane_b_store_n_i)) begin
            mem_b[addr_i] <= data_i[DATA_W-1:LANE_W];
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_o <= '0;
      end else begin
         data_o <= {mem_b[cur_addr], mem_a[cur_addr]};
      end
   end

   always_comb begin
      data_oe_n_o = 1'b1;
      if (awake && cyc_q == SSB_READ && !output_enable_n_i && !wr_ind) begin
         data_oe_n_o = 1'b0;
      end
      if (cyc_q == SSB_WRITE) begin
         data_oe_n_o = 1'b1;
      end
   end

   // Sleep sequencer next values
   always_comb begin
      slp_d = slp_q;
      slp_cnt_d = slp_cnt_q;
      case (slp_q)
         SSB_AWAKE: begin
            if (sleep_request_i) begin
               slp_d = SSB_ENTER;
               slp_cnt_d = SLEEP_CNT_ZERO;
            end
         end
         SSB_ENTER: begin
            if (slp_cnt_q == SLEEP_CNT_MAX) begin
               slp_d = SSB_ASLEEP;
            end else begin
               slp_cnt_d = slp_cnt_q + 2'h1;
            end
         end
         SSB_ASLEEP: begin
            if (!sleep_request_i) begin
               slp_d = SSB_EXIT;
               slp_cnt_d = SLEEP_CNT_ZERO;
            end
         end
         default: begin
            if (slp_cnt_q == SLEEP_CNT_MAX) begin
               slp_d = SSB_AWAKE;
            end else begin
               slp_cnt_d = slp_cnt_q + 2'h1;
            end
         end
      endcase
   end

   // Sleep sequencer registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         slp_q <= SSB_AWAKE;
         slp_cnt_q <= SLEEP_CNT_ZERO;
      end else begin
         slp_q <= slp_d;
         slp_cnt_q <= slp_cnt_d;
      end
   end

   assign asleep_o = (slp_q == SSB_ASLEEP);
endmodule

// file: bench/ssb_bus_model.sv
// Controller side of the shared data bus
`timescale 1ns/1ps
module ssb_bus_model (
   input wire logic clk_i,
   input wire logic drive_i,
   input wire logic [ssb_pkg::DATA_W-1:0] wdata_i,
   input wire logic dev_oe_n_i,
   output logic [ssb_pkg::DATA_W-1:0] bus_o,
   output logic clash_o
);
   logic [ssb_pkg::DATA_W-1:0] idle_q = '0;
   logic clash_q = 1'b0;
   // Released bus wanders each cycle
   assign bus_o = drive_i ? wdata_i : idle_q;
   always @(posedge clk_i) begin
      idle_q <= ~bus_o;
      if (drive_i && !dev_oe_n_i) clash_q <= 1'b1;
   end
   assign clash_o = clash_q;
endmodule

// file: bench/ssb_access_monitor.sv
// Port checks of the burst SRAM access control
`timescale 1ns/1ps
module ssb_access_monitor (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic processor_addr_strobe_n_i,
   input wire logic controller_addr_strobe_n_i,
   input wire logic burst_advance_n_i,
   input wire logic chip_sel_first_n_i,
   input wire logic chip_sel_second_i,
   input wire logic chip_sel_third_n_i,
   input wire logic global_store_n_i,
   input wire logic lane_store_enable_n_i,
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i,
   input wire logic [ssb_pkg::DATA_W-1:0] data_o,
   input wire logic data_oe_n_o,
   input wire logic asleep_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic sel, cont, rd;
   // Decoded selects, continuation and read cycles
   assign sel = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i;
   assign cont = processor_addr_strobe_n_i && controller_addr_strobe_n_i;
   assign rd = global_store_n_i && lane_store_enable_n_i;
   a_write_floats: assert property (!global_store_n_i && processor_addr_strobe_n_i |-> data_oe_n_o)
      else $error("data driven in write cycle");
   a_oe_float: assert property (output_enable_n_i |-> data_oe_n_o)
      else $error("data driven with output enable high");
   a_sleep_float: assert property (asleep_o |-> data_oe_n_o)
      else $error("data driven while asleep");
   a_sleep_entry: assert property ($rose(sleep_request_i) ##1 sleep_request_i[*3] |-> asleep_o)
      else $error("sleep not entered");
   a_sleep_early: assert property ($rose(sleep_request_i) |=> !asleep_o)
      else $error("sleep entered too early");
   a_sleep_exit: assert property ($fell(sleep_request_i) ##1 !sleep_request_i[*3] |-> !asleep_o)
      else $error("sleep not left");
   a_read_drive: assert property (sel && !processor_addr_strobe_n_i && !sleep_request_i && !asleep_o
      ##1 cont && !output_enable_n_i && rd |-> !data_oe_n_o) else $error("read data not driven");
   a_desel_float: assert property (!controller_addr_strobe_n_i && chip_sel_first_n_i ##1 cont
      |-> data_oe_n_o) else $error("driven after deselect");
   a_suspend_hold: assert property ((!data_oe_n_o && cont && burst_advance_n_i && rd)[*2]
      |=> $stable(data_o)) else $error("suspended read changed");
endmodule
bind ssb_access_ctrl ssb_access_monitor mon (
   .clk_i(clk_i),
   .resetn_i(resetn_i),
   .processor_addr_strobe_n_i(processor_addr_strobe_n_i),
   .controller_addr_strobe_n_i(controller_addr_strobe_n_i),
   .burst_advance_n_i(burst_advance_n_i),
   .chip_sel_first_n_i(chip_sel_first_n_i),
   .chip_sel_second_i(chip_sel_second_i),
   .chip_sel_third_n_i(chip_sel_third_n_i),
   .global_store_n_i(global_store_n_i),
   .lane_store_enable_n_i(lane_store_enable_n_i),
   .output_enable_n_i(output_enable_n_i),
   .sleep_request_i(sleep_request_i),
   .data_o(data_o),
   .data_oe_n_o(data_oe_n_o),
   .asleep_o(asleep_o)
);

// file: bench/sync_sram_burst_access_control_bench.sv
// Self-checking bench for the burst SRAM access control
`timescale 1ns/1ps
module sync_sram_burst_access_control_bench;
   import ssb_pkg::*;
   localparam logic [15:0] UP = 16'h9a5c;
   logic clk_i = 1'b0, resetn_i = 1'b0, drv = 1'b0, clash, data_oe_n_o, asleep_o;
   logic [ADDR_W-1:0] addr_i = '0;
   logic processor_addr_strobe_n_i = 1'b1, controller_addr_strobe_n_i = 1'b1;
   logic burst_advance_n_i = 1'b1, chip_sel_first_n_i = 1'b1, chip_sel_second_i = 1'b0;
   logic chip_sel_third_n_i = 1'b1, global_store_n_i = 1'b1, lane_store_enable_n_i = 1'b1;
   logic lane_a_store_n_i = 1'b1, lane_b_store_n_i = 1'b1, output_enable_n_i = 1'b1;
   logic burst_order_i = 1'b0, sleep_request_i = 1'b0;
   logic [DATA_W-1:0] data_i, data_o, wdata = '0;
   logic [DATA_W-1:0] mem [4];
   int num_errors = 0, n_compared = 0;
   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;
   ssb_access_ctrl dut (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .addr_i(addr_i),
      .processor_addr_strobe_n_i(processor_addr_strobe_n_i),
      .controller_addr_strobe_n_i(controller_addr_strobe_n_i),
      .burst_advance_n_i(burst_advance_n_i),
      .chip_sel_first_n_i(chip_sel_first_n_i),
      .chip_sel_second_i(chip_sel_second_i),
      .chip_sel_third_n_i(chip_sel_third_n_i),
      .global_store_n_i(global_store_n_i),
      .lane_store_enable_n_i(lane_store_enable_n_i),
      .lane_a_store_n_i(lane_a_store_n_i),
      .lane_b_store_n_i(lane_b_store_n_i),
      .output_enable_n_i(output_enable_n_i),
      .burst_order_i(burst_order_i),
      .sleep_request_i(sleep_request_i),
      .data_i(data_i),
      .data_o(data_o),
      .data_oe_n_o(data_oe_n_o),
      .asleep_o(asleep_o)
   );
   ssb_bus_model host (.clk_i(clk_i), .drive_i(drv), .wdata_i(wdata),
      .dev_oe_n_i(data_oe_n_o), .bus_o(data_i), .clash_o(clash));
   task automatic cmp(input string what, input logic [DATA_W-1:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [1:0] nxt(input logic [1:0] s, c);
      return burst_order_i ? s ^ c : s + c;
   endfunction
   // One bus cycle at the falling edge; w is store, lane enable, lane A, lane B
   task automatic put(input logic ps, cs, burst_advance_n, sel, input logic [3:0] w, input logic oe,
         input logic [1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clk_i);
      {processor_addr_strobe_n_i, controller_addr_strobe_n_i, burst_advance_n_i} = {ps, cs, burst_advance_n};
      {chip_sel_first_n_i, chip_sel_second_i, chip_sel_third_n_i} = {!sel, sel, !sel};
      {global_store_n_i, lane_store_enable_n_i, lane_a_store_n_i, lane_b_store_n_i} = w;
      output_enable_n_i = oe;
      addr_i = {UP, a};
      wdata = d;
      drv = (w != 4'hf);
      #1;
   endtask
   // Read burst, processor strobe low, store inputs low but ignored
   task automatic rd(input logic cs, input logic [1:0] s, input int n, input logic [7:0] hold);
      logic [1:0] c;
      c = 2'h0;
      put(1'b0, cs, 1'b1, 1'b1, 4'h0, 1'b1, s, 18'h3c3c3);
      for (int k = 0; k < n; k++) begin
         put(1'b1, 1'b1, hold[k], 1'b1, 4'hf, 1'b0, s, '0);
         cmp("read data", mem[nxt(s, c)], data_o);
         cmp("drive enable", '0, DATA_W'(data_oe_n_o));
         if (!hold[k]) c++;
      end
      put(1'b1, 1'b0, 1'b1, 1'b0, 4'hf, 1'b1, s, '0);
   endtask
   // Linear write burst with continue, suspend and first select high
   task automatic t_write_burst();
      logic [1:0] c;
      logic [4:0] psv, burst_advance_n, oev;
      {psv, burst_advance_n, oev, c} = {5'h1a, 5'h08, 5'h16, 2'h0};
      burst_order_i = 1'b0;
      put(1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 1'b1, 2'h1, 18'h2a000);
      mem[1] = 18'h2a000;
      cmp("write float", DATA_W'(1'b1), DATA_W'(data_oe_n_o));
      for (int k = 1; k < 5; k++) begin
         if (!burst_advance_n[k]) c++;
         put(psv[k], 1'b1, burst_advance_n[k], psv[k], (k == 3) ? 4'h7 : 4'h0, oev[k], 2'h1, 18'h2a000 + k);
         mem[nxt(2'h1, c)] = 18'h2a000 + k;
         cmp("write float", DATA_W'(1'b1), DATA_W'(data_oe_n_o));
      end
      put(1'b1, 1'b0, 1'b1, 1'b0, 4'hf, 1'b1, 2'h0, '0);
   endtask
   // Lane writes, then both strobes low with stores low
   task automatic t_lanes();
      burst_order_i = 1'b0;
      put(1'b0, 1'b1, 1'b1, 1'b1, 4'h0, 1'b1, 2'h0, 18'h3ffff);
      put(1'b1, 1'b1, 1'b1, 1'b1, 4'h9, 1'b1, 2'h0, 18'h3ffff);
      mem[0][8:0] = 9'h1ff;
      put(1'b1, 1'b0, 1'b1, 1'b0, 4'hf, 1'b1, 2'h0, '0);
      put(1'b1, 1'b0, 1'b1, 1'b1, 4'ha, 1'b1, 2'h1, 18'h00000);
      mem[1][17:9] = 9'h000;
      put(1'b1, 1'b0, 1'b1, 1'b0, 4'hf, 1'b1, 2'h0, '0);
      put(1'b1, 1'b0, 1'b1, 1'b1, 4'hf, 1'b1, 2'h1, '0);
      put(1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 1'b0, 2'h1, '0);
      cmp("lane read", mem[1], data_o);
      cmp("drive enable", '0, DATA_W'(data_oe_n_o));
      rd(1'b0, 2'h3, 4, 8'h00);
   endtask
   // Sleep entry, floating pins, exit and data retention
   task automatic t_sleep();
      put(1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 1'b0, 2'h0, '0);
      put(1'b0, 1'b0, 1'b1, 1'b0, 4'hf, 1'b0, 2'h0, '0);
      cmp("drive enable", '0, DATA_W'(data_oe_n_o));
      put(1'b0, 1'b1, 1'b1, 1'b0, 4'hf, 1'b0, 2'h0, '0);
      cmp("deselect float", DATA_W'(1'b1), DATA_W'(data_oe_n_o));
      sleep_request_i = 1'b1;
      repeat (4) put(1'b1, 1'b0, 1'b1, 1'b0, 4'hf, 1'b0, 2'h0, '0);
      cmp("asleep", DATA_W'(1'b1), DATA_W'(asleep_o));
      cmp("sleep float", DATA_W'(1'b1), DATA_W'(data_oe_n_o));
      sleep_request_i = 1'b0;
      repeat (3) put(1'b1, 1'b1, 1'b1, 1'b0, 4'hf, 1'b1, 2'h0, '0);
      cmp("awake", '0, DATA_W'(asleep_o));
      rd(1'b1, 2'h0, 2, 8'h00);
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(negedge clk_i);
      resetn_i = 1'b1;
      t_write_burst();
      burst_order_i = 1'b1;
      rd(1'b1, 2'h2, 6, 8'h06);
      t_lanes();
      t_sleep();
      cmp("bus clash", '0, DATA_W'(clash));
      tally_and_finish();
   end
   // Hang guard
   initial begin
      repeat (3000) @(posedge clk_i);
      num_errors++;
      tally_and_finish();
   end
endmodule
